// ==== core/cgr_pkg.sv ====
// Constants of the clock generator configuration register bank.
// Assumes a single 100 MHz register clock; the serial link is sampled, not clocked.
package cgr_pkg;

  // Register indices
  localparam logic [7:0] CGR_IDX_SPREAD     = 8'h01;
  localparam logic [7:0] CGR_IDX_EDGE_RATE  = 8'h02;
  localparam logic [7:0] CGR_IDX_REF_CTRL   = 8'h03;
  localparam logic [7:0] CGR_IDX_UNUSED     = 8'h04;
  localparam logic [7:0] CGR_IDX_REVISION   = 8'h05;
  localparam logic [7:0] CGR_IDX_FAMILY     = 8'h06;
  localparam logic [7:0] CGR_IDX_READ_LEN   = 8'h07;
  localparam logic [7:0] CGR_NUM_IDX        = 8'h08;

  // Writable bits per byte, byte 7 in the top lane down to byte 0
  localparam logic [63:0] CGR_WR_MASK = 64'h1f00_0000_f0dd_3b00;
  // Reset values per byte, reserved defaults included
  localparam logic [63:0] CGR_RST_VAL = 64'h0800_0000_5cdd_0600;

  // Field positions in byte 1
  localparam int CGR_B1_STRAP_LSB  = 6;
  localparam int CGR_B1_OVERRIDE   = 5;
  localparam int CGR_B1_SW_LSB     = 3;
  localparam int CGR_B1_AMP_LSB    = 0;
  // Field positions in byte 3
  localparam int CGR_B3_EDGE_LSB   = 6;
  localparam int CGR_B3_WAKE       = 5;
  localparam int CGR_B3_REF_OE     = 4;
  // Field width in byte 7
  localparam int CGR_B7_LEN_BITS   = 5;

  // Strap readback codes
  localparam logic [1:0] CGR_STRAP_LOW  = 2'h0;
  localparam logic [1:0] CGR_STRAP_MID  = 2'h1;
  localparam logic [1:0] CGR_STRAP_HIGH = 2'h3;

  // Bit counter marks
  localparam logic [3:0] CGR_BIT_LAST = 4'h8;
  localparam logic [3:0] CGR_BIT_ACK  = 4'h9;

  typedef enum logic [2:0] {
    CGR_ST_IDLE  = 3'h0,
    CGR_ST_ADDR  = 3'h1,
    CGR_ST_INDEX = 3'h2,
    CGR_ST_COUNT = 3'h3,
    CGR_ST_WDATA = 3'h4,
    CGR_ST_RDATA = 3'h5
  } cgr_state_e;

endpackage

// ==== core/cgr_reg_if.sv ====
// Carrier between the serial engine and the register storage.
// Assumes both ends run on the same register clock.
`timescale 1ns/1ns
interface cgr_reg_if;
  import cgr_pkg::*;
  logic        wr_stb;
  logic [7:0]  wr_index;
  logic [7:0]  wr_data;
  logic [7:0]  rd_index;
  logic [7:0]  rd_data;
  logic [1:0]  strap_code;
  logic [63:0] image;

  modport engine (output wr_stb, output wr_index, output wr_data, output rd_index,
                  output strap_code, input rd_data, input image);
  modport bank   (input wr_stb, input wr_index, input wr_data, input rd_index,
                  input strap_code, output rd_data, output image);
endinterface // cgr_reg_if

// ==== core/cgr_reg_bank.sv ====
// Register storage: eight byte entries with write masks and fixed read values.
// Assumes write strobes arrive as one-cycle pulses from the serial engine.
`timescale 1ns/1ns
module cgr_reg_bank import cgr_pkg::*; #(
  parameter logic [7:0] REV_BYTE    = 8'h00,
  parameter logic [7:0] FAMILY_BYTE = 8'h00
) (
  input wire logic  clk_in,
  input wire logic  reset_n_in,
  cgr_reg_if.bank   bus
);

  logic [63:0] fixed_val;

  // Read-only content: reserved defaults, identity bytes, strap readback
  assign fixed_val = CGR_RST_VAL | {8'h00, FAMILY_BYTE, REV_BYTE, 40'h0}
                   | {48'h0, bus.strap_code, 6'h00, 8'h00};

  // One masked storage byte per index
  for (genvar i = 0; i < 8; i++) begin : g_byte
    logic [7:0] byte_q;
    localparam logic [7:0] MASK = CGR_WR_MASK[i*8 +: 8];
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        byte_q <= CGR_RST_VAL[i*8 +: 8];
      end else if (bus.wr_stb && bus.wr_index == 8'(i)) begin
        byte_q <= (byte_q & ~MASK) | (bus.wr_data & MASK);
      end
    end
    assign bus.image[i*8 +: 8] = (byte_q & MASK) | (fixed_val[i*8 +: 8] & ~MASK);
  end

  // Read port; indices past the table read zero
  assign bus.rd_data = (bus.rd_index < CGR_NUM_IDX) ? bus.image[bus.rd_index[2:0]*8 +: 8]
                                                      : 8'h00;

  AST_RO_IDENT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    bus.image[55:40] == {FAMILY_BYTE, REV_BYTE})
    else $error("Identity bytes changed");
  AST_RSVD_BITS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    bus.wr_stb |=> (bus.image[15:8] & 8'h04) == 8'h04 && (bus.image[23:16] & 8'h22) == 8'h00
                   && bus.image[39:32] == 8'h00 && bus.image[63:61] == 3'h0
                   && (bus.image[31:24] & 8'h0c) == 8'h0c && bus.image[7:0] == 8'h00)
    else $error("Reserved bits disturbed by a write");

endmodule // cgr_reg_bank

// ==== core/cgr_smbus_regs.sv ====
// Serial-managed configuration block of a differential clock generator.
// Assumes the serial clock and data pins and the straps are asynchronous to ref_clk_in.
// Notes on behaviour
// - Byte 1 bits 7:6 read latched spread strap: 00 low, 01 mid, 11 high.
// - Byte 1 bit 5 override, default 0, makes bits 4:3 pick spread.
// - Software spread code: 00 off, 01 -0.25%, 10 reserved, 11 -0.5%.
// - With override clear the stored software spread field has no effect.
// - Byte 1 bits 1:0 select amplitude 0.55/0.65/0.7/0.8V, reset 10.
// - Byte 2 holds per-output edge-rate bits, default 1; bits 5,1 reserved.
// - Edge-rate bit 0 means slow, 1 means fast.
// - Byte 3 bits 7:6 pick reference edge rate, reset 01.
// - Byte 3 bit 5 keeps reference running in power down, default off.
// - Byte 3 bit 4 clear forces reference low; default 1.
// - Byte 5 read-only: revision nibble high, maker nibble low.
// - Byte 6 read-only: two-bit family type, six-bit part code.
// - Byte 7 bits 4:0 set block read length, reset 8.
// - Block write: index, count, then bytes stored in turn, each acknowledged.
// - Block read: count first, then bytes; host nacks then stops.
`timescale 1ns/1ns
module cgr_smbus_regs import cgr_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR  = 7'h2a,  // Arbitrary default
  parameter logic [3:0] REV_CODE    = 4'h5,   // Arbitrary value
  parameter logic [3:0] MAKER_CODE  = 4'h9,   // Arbitrary value
  parameter logic [1:0] FAMILY_TYPE = 2'h2,   // Arbitrary value
  parameter logic [5:0] PART_CODE   = 6'h2d   // Arbitrary value
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       power_good_down_n_in,
  input  wire logic [1:0] spread_strap_in,
  input  wire logic       smbus_clk_in,
  input  wire logic       smbus_data_in,
  output logic            smbus_data_out,
  output logic            smbus_data_oe_out,
  output logic [1:0]      spread_select_out,
  output logic [1:0]      amplitude_sel_out,
  output logic [5:0]      edge_rate_out,
  output logic [1:0]      ref_edge_rate_out,
  output logic            ref_run_out
);

  cgr_reg_if rif ();

  logic       scl_meta_q, scl_sync_q, scl_prev_q;
  logic       sda_meta_q, sda_sync_q, sda_prev_q;
  logic       pg_meta_q, pg_sync_q, pg_prev_q;
  logic [1:0] strap_meta_q, strap_sync_q;
  logic [1:0] strap_code_q;
  logic       scl_rise, scl_fall, start_det, stop_det;
  cgr_state_e st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, idx_q, remain_q;
  logic       read_q, host_nack_q, oe_q, sda_o_q;
  logic       wr_stb_q;
  logic [7:0] wr_index_q, wr_data_q;
  logic [7:0] b1, b2, b3;

  // Two-stage synchronisers for every asynchronous input
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_meta_q   <= 1'b1;
      scl_sync_q   <= 1'b1;
      scl_prev_q   <= 1'b1;
      sda_meta_q   <= 1'b1;
      sda_sync_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      pg_meta_q    <= 1'b0;
      pg_sync_q    <= 1'b0;
      pg_prev_q    <= 1'b0;
      strap_meta_q <= 2'h0;
      strap_sync_q <= 2'h0;
    end else begin
      scl_meta_q   <= smbus_clk_in;
      scl_sync_q   <= scl_meta_q;
      scl_prev_q   <= scl_sync_q;
      sda_meta_q   <= smbus_data_in;
      sda_sync_q   <= sda_meta_q;
      sda_prev_q   <= sda_sync_q;
      pg_meta_q    <= power_good_down_n_in;
      pg_sync_q    <= pg_meta_q;
      pg_prev_q    <= pg_sync_q;
      strap_meta_q <= spread_strap_in;
      strap_sync_q <= strap_meta_q;
    end
  end

  // Link events found from the sampled pins
  assign scl_rise  = scl_sync_q & ~scl_prev_q;
  assign scl_fall  = ~scl_sync_q & scl_prev_q;
  assign start_det = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  assign stop_det  = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

  // Strap level caught on each rise of power good, coded for readback
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_code_q <= CGR_STRAP_LOW;
    end else if (pg_sync_q && !pg_prev_q) begin
      unique case (strap_sync_q)
        2'h0:    strap_code_q <= CGR_STRAP_LOW;
        2'h1:    strap_code_q <= CGR_STRAP_MID;
        default: strap_code_q <= CGR_STRAP_HIGH;
      endcase
    end
  end

  // Serial byte engine: address, index, count, write data and read data
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q        <= CGR_ST_IDLE;
      bit_cnt_q   <= 4'h0;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      idx_q       <= 8'h00;
      remain_q    <= 8'h00;
      read_q      <= 1'b0;
      host_nack_q <= 1'b0;
      oe_q        <= 1'b0;
    end else if (start_det) begin
      st_q      <= CGR_ST_ADDR;
      bit_cnt_q <= 4'h0;
      oe_q      <= 1'b0;
    end else if (stop_det) begin
      st_q <= CGR_ST_IDLE;
      oe_q <= 1'b0;
    end else if (scl_rise && st_q != CGR_ST_IDLE) begin
      if (bit_cnt_q < CGR_BIT_LAST) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (st_q != CGR_ST_RDATA) begin
          rx_q <= {rx_q[6:0], sda_sync_q};
        end
      end else if (bit_cnt_q == CGR_BIT_ACK && st_q == CGR_ST_RDATA) begin
        host_nack_q <= sda_sync_q;
      end
    end else if (scl_fall && st_q != CGR_ST_IDLE) begin
      if (st_q == CGR_ST_RDATA) begin
        if (bit_cnt_q < CGR_BIT_LAST && bit_cnt_q != 4'h0) begin
          oe_q <= ~tx_q[3'(4'h7 - bit_cnt_q)];
        end else if (bit_cnt_q == CGR_BIT_LAST) begin
          oe_q      <= 1'b0;                                     // Release for host ack
          bit_cnt_q <= CGR_BIT_ACK;
        end else if (bit_cnt_q == CGR_BIT_ACK) begin
          if (host_nack_q) begin
            st_q <= CGR_ST_IDLE;
          end else begin
            tx_q      <= (remain_q != 8'h00) ? rif.rd_data : 8'hff;
            oe_q      <= (remain_q != 8'h00) ? ~rif.rd_data[7] : 1'b0;
            idx_q     <= idx_q + 8'h01;
            remain_q  <= (remain_q != 8'h00) ? remain_q - 8'h01 : 8'h00;
            bit_cnt_q <= 4'h0;
          end
        end
      end else if (bit_cnt_q == CGR_BIT_LAST) begin
        bit_cnt_q <= CGR_BIT_ACK;
        unique case (st_q)
          CGR_ST_ADDR: begin
            if (rx_q[7:1] == SLAVE_ADDR) begin
              oe_q   <= 1'b1;
              read_q <= rx_q[0];
            end else begin
              st_q <= CGR_ST_IDLE;                               // Not our address
            end
          end
          CGR_ST_INDEX: begin
            oe_q  <= 1'b1;
            idx_q <= rx_q;
          end
          CGR_ST_COUNT: begin
            oe_q     <= 1'b1;
            remain_q <= rx_q;
          end
          CGR_ST_WDATA: begin
            oe_q <= (remain_q != 8'h00);
            if (remain_q != 8'h00) begin
              idx_q    <= idx_q + 8'h01;
              remain_q <= remain_q - 8'h01;
            end
          end
          default: st_q <= CGR_ST_IDLE;
        endcase
      end else if (bit_cnt_q == CGR_BIT_ACK) begin
        oe_q      <= 1'b0;
        bit_cnt_q <= 4'h0;
        unique case (st_q)
          CGR_ST_ADDR: begin
            if (read_q) begin
              st_q     <= CGR_ST_RDATA;
              tx_q     <= {3'h0, b1_len()};
              oe_q     <= 1'b1;                                  // Count MSB is always 0
              remain_q <= {3'h0, b1_len()};
            end else begin
              st_q <= CGR_ST_INDEX;
            end
          end
          CGR_ST_INDEX: st_q <= CGR_ST_COUNT;
          CGR_ST_COUNT: st_q <= CGR_ST_WDATA;
          CGR_ST_WDATA: st_q <= CGR_ST_WDATA;
          default:      st_q <= CGR_ST_IDLE;
        endcase
      end
    end
  end

  // Byte count field of byte 7
  function automatic logic [CGR_B7_LEN_BITS-1:0] b1_len();
    b1_len = rif.image[CGR_IDX_READ_LEN[2:0]*8 +: CGR_B7_LEN_BITS];
  endfunction

  // One-cycle write strobe on the ack of each counted data byte
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_stb_q   <= 1'b0;
      wr_index_q <= 8'h00;
      wr_data_q  <= 8'h00;
    end else begin
      wr_stb_q <= scl_fall && !start_det && !stop_det && st_q == CGR_ST_WDATA
                  && bit_cnt_q == CGR_BIT_LAST && remain_q != 8'h00;
      wr_index_q <= idx_q;
      wr_data_q  <= rx_q;
    end
  end

  // Open-drain data: output level held low, enable pulls the line
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign smbus_data_out    = sda_o_q;
  assign smbus_data_oe_out = oe_q;

  assign rif.wr_stb     = wr_stb_q;
  assign rif.wr_index   = wr_index_q;
  assign rif.wr_data    = wr_data_q;
  assign rif.rd_index   = idx_q;
  assign rif.strap_code = strap_code_q;

  cgr_reg_bank #(
    .REV_BYTE    ({REV_CODE, MAKER_CODE}),
    .FAMILY_BYTE ({FAMILY_TYPE, PART_CODE})
  ) u_bank (
    .clk_in     (ref_clk_in),
    .reset_n_in (reset_n_in),
    .bus        (rif.bank)
  );

  assign b1 = rif.image[15:8];
  assign b2 = rif.image[23:16];
  assign b3 = rif.image[31:24];

  // Registered control outputs toward the analog sections
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spread_select_out <= CGR_STRAP_LOW;
      amplitude_sel_out <= CGR_RST_VAL[9:8];
      edge_rate_out     <= 6'h3f;
      ref_edge_rate_out <= CGR_RST_VAL[31:30];
      ref_run_out       <= 1'b0;
    end else begin
      spread_select_out <= b1[CGR_B1_OVERRIDE] ? b1[CGR_B1_SW_LSB +: 2]
                                               : strap_code_q;
      amplitude_sel_out <= b1[CGR_B1_AMP_LSB +: 2];
      edge_rate_out     <= {b2[7:6], b2[4:2], b2[0]};
      ref_edge_rate_out <= b3[CGR_B3_EDGE_LSB +: 2];
      ref_run_out       <= b3[CGR_B3_REF_OE]
                           & (pg_sync_q | b3[CGR_B3_WAKE]);
    end
  end

  // Last stored index within the current frame, kept only for the write order check;
  // a new start forgets it so that each block write begins its own sequence
  logic       wr_seen_q;
  logic [7:0] wr_last_q;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_seen_q <= 1'b0;
      wr_last_q <= 8'h00;
    end else if (start_det) begin
      wr_seen_q <= 1'b0;
    end else if (wr_stb_q) begin
      wr_seen_q <= 1'b1;
      wr_last_q <= wr_index_q;
    end
  end

  AST_STRAP_CODE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    strap_code_q != 2'h2 && rif.image[15:14] == strap_code_q)
    else $error("Strap readback code illegal");
  AST_SW_OVERRIDE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    b1[CGR_B1_OVERRIDE] |=> spread_select_out == $past(b1[4:3]))
    else $error("Software spread not applied under override");
  AST_SW_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !b1[CGR_B1_OVERRIDE] |=> spread_select_out == $past(strap_code_q))
    else $error("Software spread leaked without override");
  AST_AMPLITUDE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ##1 amplitude_sel_out == $past(b1[1:0]))
    else $error("Amplitude output does not follow byte 1");
  AST_EDGE_MAP: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ##1 edge_rate_out[5] == $past(b2[7]) && edge_rate_out[3] == $past(b2[4])
        && edge_rate_out[0] == $past(b2[0]))
    else $error("Edge-rate bit mapping wrong");
  AST_REF_EDGE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ##1 ref_edge_rate_out == $past(b3[7:6]))
    else $error("Reference edge rate wrong");
  AST_REF_PD: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (!pg_sync_q && !b3[CGR_B3_WAKE]) |=> !ref_run_out)
    else $error("Reference runs in power down without wake");
  AST_REF_OE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !b3[CGR_B3_REF_OE] |=> !ref_run_out)
    else $error("Reference not held low while disabled");
  AST_WRITE_ORDER: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (wr_stb_q && wr_seen_q) |-> wr_index_q == wr_last_q + 8'h01)
    else $error("Block write index did not advance");
  AST_WRITE_IN_FRAME: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_stb_q |-> st_q == CGR_ST_WDATA && bit_cnt_q == CGR_BIT_ACK)
    else $error("Write strobe outside a counted data byte");
  AST_STRAP_LATCH: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (pg_sync_q && !pg_prev_q) |=> strap_code_q == ($past(strap_sync_q[1]) ? CGR_STRAP_HIGH
                                                   : $past(strap_sync_q)))
    else $error("Strap level not latched on power good");
  AST_READ_PAST_COUNT: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == CGR_ST_RDATA && scl_fall && !start_det && !stop_det && bit_cnt_q == CGR_BIT_ACK
     && !host_nack_q && remain_q == 8'h00) |=> tx_q == 8'hff && !oe_q)
    else $error("Read past the byte count did not return ff");
  AST_READ_COUNT: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == CGR_ST_ADDR && read_q && bit_cnt_q == CGR_BIT_ACK && scl_fall
     && !start_det && !stop_det) |=> tx_q == {3'h0, $past(b1_len())} && st_q == CGR_ST_RDATA)
    else $error("Block read did not open with the byte count");

endmodule // cgr_smbus_regs

// ==== dv/cgr_smbus_host.sv ====
// Behavioural SMBus host: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the open-drain data line with a pull-up into sda_in.
`timescale 1ns/1ns
module cgr_smbus_host (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // Clock stands high and data is released between frames
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // One bit cell of 125 ns: data moves 42 ns after the fall, is sampled late in high
  task automatic bit_cell(input logic tx, output logic rx);
    #42 sda_oe_out = ~tx;
    #43 scl_out = 1'b1;
    #35 rx = sda_in;
    #5 scl_out = 1'b0;
  endtask

  // Start, or repeated start when the clock is low
  task automatic start_c();
    if (!scl_out) begin
      #42 sda_oe_out = 1'b0;
      #43 scl_out = 1'b1;
    end
    #40 sda_oe_out = 1'b1;
    #40 scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_c();
    #42 sda_oe_out = 1'b1;
    #43 scl_out = 1'b1;
    #40 sda_oe_out = 1'b0;
    #40;
  endtask

  // Byte MSB first, then the ack cell; ack_bit 1 releases the line there
  task automatic xbyte(input logic [7:0] tx, input logic ack_bit,
                       output logic [7:0] rx, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(tx[i], r);
      rx[i] = r;
    end
    bit_cell(ack_bit, r);
    acked = ~r;
  endtask

  // Block write: index, count, then the data bytes; counts acks seen
  task automatic blk_write(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] cnt, input int nsend,
                           input logic [7:0] d [8], output int acks);
    logic [7:0] rx;
    logic       a;
    acks = 0;
    start_c();
    xbyte({addr, 1'b0}, 1'b1, rx, a);
    acks += int'(a);
    xbyte(idx, 1'b1, rx, a);
    acks += int'(a);
    xbyte(cnt, 1'b1, rx, a);
    acks += int'(a);
    for (int k = 0; k < nsend; k++) begin
      xbyte(d[k], 1'b1, rx, a);
      acks += int'(a);
    end
    stop_c();
  endtask

  // Block read: index, repeated start, then n bytes acked with the last one refused
  task automatic blk_read(input logic [6:0] addr, input logic [7:0] idx, input int n,
                          output logic [7:0] q [9]);
    logic [7:0] rx;
    logic       a;
    start_c();
    xbyte({addr, 1'b0}, 1'b1, rx, a);
    xbyte(idx, 1'b1, rx, a);
    start_c();
    xbyte({addr, 1'b1}, 1'b1, rx, a);
    for (int k = 0; k < n; k++) begin
      xbyte(8'hff, k == n - 1, q[k], a);
    end
    stop_c();
  endtask
endmodule // cgr_smbus_host

// ==== dv/tb.sv ====
// Self-checking bench for the serial configuration block.
// Assumes the host model in cgr_smbus_host and a pull-up on the data line.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import cgr_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  localparam logic [3:0] REV  = 4'h3;  // Arbitrary value
  localparam logic [3:0] MKR  = 4'hc;  // Arbitrary value
  localparam logic [1:0] FAM  = 2'h1;  // Arbitrary value
  localparam logic [5:0] PART = 6'h17; // Arbitrary value
  logic       clk, rst_n, pgd_n, scl, host_oe, dut_sda, dut_oe, ref_run;
  logic [1:0] strap, spread, amp, ref_edge;
  logic [5:0] edge_r;
  logic [7:0] img [8];
  logic [7:0] wd [8];
  logic [7:0] rq [9];
  int         errors, n_compared, acks;
  // Open-drain line with pull-up: low while either side pulls
  wire sda = ~(host_oe | (dut_oe & ~dut_sda));

  cgr_smbus_regs #(.SLAVE_ADDR(ADDR), .REV_CODE(REV), .MAKER_CODE(MKR),
    .FAMILY_TYPE(FAM), .PART_CODE(PART)) DUT (
    .ref_clk_in(clk), .reset_n_in(rst_n), .power_good_down_n_in(pgd_n),
    .spread_strap_in(strap), .smbus_clk_in(scl), .smbus_data_in(sda),
    .smbus_data_out(dut_sda), .smbus_data_oe_out(dut_oe), .spread_select_out(spread),
    .amplitude_sel_out(amp), .edge_rate_out(edge_r), .ref_edge_rate_out(ref_edge),
    .ref_run_out(ref_run));
  cgr_smbus_host host (.sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));

  // Power good and strap change just after a clock edge; strap latches on the rise
  task automatic set_pg(input logic v, input logic [1:0] s);
    @(posedge clk);
    #1 strap = s;
    pgd_n = v;
    if (v) img[1][7:6] = s[1] ? CGR_STRAP_HIGH : s;
    repeat (6) @(posedge clk);
  endtask

  // Block write through the host, then the expected image follows the write masks
  task automatic wr(input logic [7:0] idx, input int n, input int nsend, input int ea);
    logic [7:0] m;
    host.blk_write(ADDR, idx, n[7:0], nsend, wd, acks);
    `CHK(acks, ea)
    for (int k = 0; k < n; k++) begin
      m = (idx + k < 8) ? CGR_WR_MASK[8 * (idx + k) +: 8] : 8'h00;
      if (idx + k < 8) img[idx + k] = (wd[k] & m) | (img[idx + k] & ~m);
    end
  endtask

  // Block read of n bytes after the count, compared with the image
  task automatic check_read(input logic [7:0] idx, input int n);
    logic [7:0] e;
    host.blk_read(ADDR, idx, n + 1, rq);
    `CHK(rq[0], {3'h0, img[7][4:0]})
    for (int k = 1; k <= n; k++) begin
      e = (k > img[7][4:0]) ? 8'hff : ((idx + k - 1 < 8) ? img[idx + k - 1] : 8'h00);
      `CHK(rq[k], e)
    end
  endtask

  // Control outputs against the image and power state
  task automatic chk_outs();
    `CHK(spread, img[1][5] ? img[1][4:3] : img[1][7:6])
    `CHK(amp, img[1][1:0])
    `CHK(edge_r, {img[2][7:6], img[2][4:2], img[2][0]})
    `CHK(ref_edge, img[3][7:6])
    `CHK(ref_run, img[3][4] & (pgd_n | img[3][5]))
    `CHK(dut_sda, 1'b0)
  endtask

  // Defaults after reset, read back as one full block
  task automatic t_defaults();
    chk_outs();
    check_read(8'h01, 8);
  endtask

  // Mixed write over reserved and read-only bits, shorter read length, read past it
  task automatic t_write_mix();
    wd = '{8'hff, 8'h00, 8'h2f, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    wr(8'h01, 3, 3, 6);
    chk_outs();
    wd[0] = 8'he3;
    wr(8'h07, 1, 1, 4);
    check_read(8'h01, 4);
    wd[0] = 8'h08;
    wr(8'h07, 1, 1, 4);
  endtask

  // Every spread and amplitude code under override, then override cleared
  task automatic t_codes();
    for (int k = 0; k < 4; k++) begin
      wd[0] = 8'h20 | (8'(k) << 3) | 8'(k);
      wr(8'h01, 1, 1, 4);
      chk_outs();
    end
    wd[0] = 8'h18;
    wr(8'h01, 1, 1, 4);
    chk_outs();
  endtask

  // Reference control across power down, edge-rate map, strap relatch at every level
  task automatic t_ref();
    logic [7:0] cfg [4];
    cfg = '{8'h30, 8'h10, 8'h00, 8'hd0};
    wd[0] = 8'h84;
    wr(8'h02, 1, 1, 4);
    for (int i = 0; i < 4; i++) begin
      wd[0] = cfg[i];
      wr(8'h03, 1, 1, 4);
      chk_outs();
      set_pg(1'b0, 2'(i));
      chk_outs();
      set_pg(1'b1, 2'(i));
      chk_outs();
    end
    check_read(8'h01, 1);
  endtask

  // Wrong address, bytes beyond the count, writes to fixed bytes
  task automatic t_refuse();
    wd[0] = 8'h5a;
    host.blk_write(ADDR ^ 7'h01, 8'h02, 8'h01, 1, wd, acks);
    `CHK(acks, 0)
    wd = '{8'h4c, 8'h00, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    wr(8'h02, 1, 2, 4);
    wd = '{8'hff, 8'hff, 8'hff, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    wr(8'h04, 3, 3, 6);
    check_read(8'h02, 6);
    chk_outs();
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Register clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    pgd_n = 1'b0;
    strap = 2'b01;
    errors = 0;
    n_compared = 0;
    for (int b = 0; b < 8; b++) img[b] = CGR_RST_VAL[8 * b +: 8];
    img[5] = {REV, MKR};
    img[6] = {FAM, PART};
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    set_pg(1'b1, 2'b01);
    t_defaults();
    t_write_mix();
    t_codes();
    t_ref();
    t_refuse();
    wrap_up();
  end
endmodule // tb
